// ===== shared/bus_if_pkg.sv
// constants shared by the external bus interface and its read buffer
// assumes a single system clock and active-low pin signalling
package bus_if_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int BURST_WORDS = 4;
  localparam int IRQ_W = 6;
  // lowest byte-address bit above a 256-word page
  localparam int PAGE_LSB = 10;
  localparam logic [2:0] IDX_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h3F;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_DRAIN = 3'b010,
    ST_WRITE = 3'b011
  } bus_state_t;
endpackage : bus_if_pkg

// ===== hw/read_word_buffer.sv
// word buffer between memory capture strobes and the execution side
// assumes the owner clears it before each read and never overfills it
`timescale 1ns/1ps
module read_word_buffer #(
  parameter int WIDTH = bus_if_pkg::DATA_W,
  parameter int DEPTH = bus_if_pkg::BURST_WORDS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  // state
  output logic [2:0] fill_count,
  output logic [2:0] pop_count,
  output logic [WIDTH-1:0] pop_data
);
  import bus_if_pkg::*;
  logic [WIDTH-1:0] store [DEPTH];
  wire [1:0] push_idx = fill_count[1:0];
  wire [1:0] pop_idx = pop_count[1:0];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          store[g] <= '0;
        end else if (push && push_idx == 2'(g)) begin
          store[g] <= push_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fill_count <= IDX_RESET;
      pop_count <= IDX_RESET;
      pop_data <= '0;
    end else if (clear) begin
      fill_count <= IDX_RESET;
      pop_count <= IDX_RESET;
    end else begin
      if (push) begin
        fill_count <= fill_count + 3'h1;
      end
      if (pop) begin
        pop_count <= pop_count + 3'h1;
        pop_data <= store[pop_idx];
      end
    end
  end
endmodule : read_word_buffer

// ===== hw/ext_bus_interface.sv
// processor-side external bus interface: read/write strobes, burst read
// buffer, acknowledge and fault handling, interrupt input registering
// assumes an external wait-state controller answers on the handshake pins
//
// Overview of operation
// - after acknowledge, drain buffer next clock
// - without acknowledge, drain after final capture
// - write ends after acknowledge sampled
// - strobe released clock after bus fault
// - fault exception only on reads
// - interrupts re-registered in run or fixup
// - reads ignore unneeded byte lanes
// - burst takes four captures, single one
// - near flag on same-page write
`timescale 1ns/1ps
module ext_bus_interface #(
  parameter int BURST_WORDS = bus_if_pkg::BURST_WORDS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // core request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic [bus_if_pkg::ADDR_W-1:0] req_addr,
  input wire logic [bus_if_pkg::DATA_W-1:0] req_wdata,
  input wire logic [bus_if_pkg::LANES-1:0] req_byte_en,
  output logic req_ready,
  // core read return side
  output logic rd_valid,
  output logic [bus_if_pkg::DATA_W-1:0] rd_data,
  output logic read_fault,
  // core execution state and interrupts
  input wire logic run_or_fixup,
  output logic [bus_if_pkg::IRQ_W-1:0] irq_level,
  // bus pins, outputs and read data input
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic burst_or_page_near_n,
  output logic [bus_if_pkg::LANES-1:0] byte_en_n,
  output logic [bus_if_pkg::ADDR_W-1:0] addr,
  output logic [bus_if_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [bus_if_pkg::DATA_W-1:0] data_in,
  // bus pins, handshake and interrupt inputs
  input wire logic bus_acknowledge_n,
  input wire logic read_word_capture_n,
  input wire logic bus_fault_n,
  input wire logic [bus_if_pkg::IRQ_W-1:0] irq_n
);
  import bus_if_pkg::*;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [2:0] hs_meta;
  logic [2:0] hs_sync;
  logic [IRQ_W-1:0] irq_meta;
  logic [IRQ_W-1:0] irq_sync;
  logic [DATA_W-1:0] din_meta;
  logic [DATA_W-1:0] din_sync;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hs_meta <= 3'h7;
      hs_sync <= 3'h7;
      irq_meta <= IRQ_RESET;
      irq_sync <= IRQ_RESET;
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      hs_meta <= {bus_fault_n, read_word_capture_n, bus_acknowledge_n};
      hs_sync <= hs_meta;
      irq_meta <= irq_n;
      irq_sync <= irq_meta;
      din_meta <= data_in;
      din_sync <= din_meta;
    end
  end

  // data follows the capture strobe through the same two stages
  wire ack_seen = !hs_sync[0];
  wire capture = !hs_sync[1];
  wire fault = !hs_sync[2];

  // ==========================================================
  // state and read buffer
  // ==========================================================
  bus_state_t state;
  bus_state_t next_state;
  logic burst;
  logic ack_taken;
  logic last_wr_valid;
  logic [ADDR_W-1:PAGE_LSB] last_wr_page;
  logic [2:0] fill_count;
  logic [2:0] pop_count;
  logic [DATA_W-1:0] pop_data;

  wire [2:0] words_expected = burst ? 3'(BURST_WORDS) : 3'h1;
  wire reading = state == ST_READ;
  // an early acknowledge moves to drain while later words are still arriving
  wire read_cycle = reading || state == ST_DRAIN;
  wire buf_push = read_cycle && capture && fill_count < words_expected;
  wire captures_done = fill_count == words_expected;
  // drain never overtakes the words already captured
  wire buf_pop = (state == ST_DRAIN) && pop_count < fill_count
    && pop_count < words_expected;
  wire drain_done = (state == ST_DRAIN) && pop_count == words_expected;
  wire start = req_valid && req_ready;
  wire near_hit = last_wr_valid && last_wr_page == req_addr[ADDR_W-1:PAGE_LSB];
  wire read_fault_hit = read_cycle && fault;

  assign req_ready = state == ST_IDLE;
  // buffer output register loads on the same edge that raises rd_valid
  assign rd_data = pop_data;

  read_word_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(BURST_WORDS)
  ) u_buf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clear(start),
    .push(buf_push),
    .push_data(din_sync),
    .pop(buf_pop),
    .fill_count(fill_count),
    .pop_count(pop_count),
    .pop_data(pop_data)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = req_write ? ST_WRITE : ST_READ;
        end
      end
      ST_READ: begin
        if (fault) begin
          next_state = ST_IDLE;
        end else if (ack_seen || ack_taken) begin
          next_state = ST_DRAIN;
        end else if (captures_done) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (fault) begin
          next_state = ST_IDLE;
        end else if (drain_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (fault || ack_seen) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // sequencing
  // ==========================================================
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      burst <= 1'b0;
      ack_taken <= 1'b0;
      last_wr_valid <= 1'b0;
      last_wr_page <= '0;
    end else begin
      state <= next_state;
      if (start) begin
        burst <= req_burst && !req_write;
        ack_taken <= 1'b0;
      end else if (state != ST_IDLE && ack_seen) begin
        ack_taken <= 1'b1;
      end
      if (start && req_write) begin
        last_wr_valid <= 1'b1;
        last_wr_page <= req_addr[ADDR_W-1:PAGE_LSB];
      end
    end
  end

  // ==========================================================
  // pin drive and core returns
  // ==========================================================
  // read strobe stays low into the drain until the last expected word is captured so capture order holds
  wire next_rd_strobe_n = !(next_state == ST_READ ||
    (next_state == ST_DRAIN && !captures_done && !(state == ST_DRAIN && captures_done)));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      burst_or_page_near_n <= 1'b1;
      byte_en_n <= '1;
      addr <= '0;
      data_out <= '0;
      data_oe_n <= 1'b1;
      rd_valid <= 1'b0;
      read_fault <= 1'b0;
      irq_level <= IRQ_RESET;
    end else begin
      rd_strobe_n <= next_rd_strobe_n || fault;
      wr_strobe_n <= next_state != ST_WRITE;
      data_oe_n <= next_state != ST_WRITE;
      if (start) begin
        addr <= req_addr;
        data_out <= req_wdata;
        // reads present all lanes; the whole word is returned on rd_data
        byte_en_n <= req_write ? ~req_byte_en : '0;
        burst_or_page_near_n <= req_write ? !near_hit : !req_burst;
      end
      rd_valid <= buf_pop;
      read_fault <= read_fault_hit;
      if (run_or_fixup) begin
        irq_level <= ~irq_sync;
      end
    end
  end
endmodule : ext_bus_interface

// ===== tb/ext_bus_interface_asserts.sv
// checker on the bus interface pins
// assumes it is bound onto the interface module
`timescale 1ns/1ps
module ext_bus_interface_asserts (
  input wire logic clk_sys, arst_n, req_burst, run_or_fixup, rd_valid,
  input wire logic rd_strobe_n, wr_strobe_n, burst_or_page_near_n,
  input wire logic bus_acknowledge_n, bus_fault_n,
  input wire logic [5:0] irq_level, irq_n,
  input wire logic [3:0] byte_en_n,
  input wire logic [31:0] addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire idle = rd_strobe_n && wr_strobe_n;
  logic [21:0] page;
  logic wrote;
  // ==========
  // last write page, judged on the pins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrote <= 1'b0;
      page <= 22'h0;
    end else if ($fell(wr_strobe_n)) begin
      wrote <= 1'b1;
      page <= addr[31:10];
    end
  end
  property p_flt; !idle && !bus_fault_n |-> ##[1:4] idle; endproperty
  a_flt: assert property (p_flt) else $error("strobe kept after fault");
  property p_wack; !wr_strobe_n && !bus_acknowledge_n |-> ##[1:4] wr_strobe_n; endproperty
  a_wack: assert property (p_wack) else $error("write not ended");
  property p_rack; !rd_strobe_n && !bus_acknowledge_n && bus_fault_n |-> ##[2:7] rd_valid;
  endproperty
  a_rack: assert property (p_rack) else $error("no drain after ack");
  property p_lanes; !rd_strobe_n |-> byte_en_n == 4'h0; endproperty
  a_lanes: assert property (p_lanes) else $error("read lanes");
  property p_hold; !run_or_fixup |=> $stable(irq_level); endproperty
  a_hold: assert property (p_hold) else $error("irq moved");
  property p_irq; (run_or_fixup && $stable(irq_n)) [*4] |-> irq_level == ~irq_n; endproperty
  a_irq: assert property (p_irq) else $error("irq not taken");
  property p_burst; $fell(rd_strobe_n) |-> burst_or_page_near_n == !$past(req_burst);
  endproperty
  a_burst: assert property (p_burst) else $error("burst flag");
  property p_near; $fell(wr_strobe_n) |-> burst_or_page_near_n == !(wrote && addr[31:10] == page);
  endproperty
  a_near: assert property (p_near) else $error("near flag");
endmodule : ext_bus_interface_asserts
bind ext_bus_interface ext_bus_interface_asserts i_chk (.clk_sys, .arst_n, .req_burst,
  .run_or_fixup, .rd_valid, .rd_strobe_n, .wr_strobe_n, .burst_or_page_near_n,
  .bus_acknowledge_n, .bus_fault_n, .irq_level, .irq_n, .byte_en_n, .addr);

// ===== tb/wait_state_model.sv
// wait-state controller and memory on the far side of the bus pins
// assumes one clock shared with the interface; mode 0 fast, 1 slow no read ack, 2 fault
`timescale 1ns/1ps
module wait_state_model (
  input wire logic clk_sys, arst_n, rd_strobe_n, wr_strobe_n, burst_or_page_near_n,
  input wire logic [1:0] mode,
  input wire logic [31:0] addr,
  output logic bus_acknowledge_n, read_word_capture_n, bus_fault_n,
  output logic [31:0] data_in
);
  logic [3:0] cnt;
  logic [1:0] idx;
  logic done;
  wire [3:0] w = (mode == 2'h1) ? 4'h3 : 4'h0;
  // done blocks a recount while the unsynchronised strobe pin is still low
  wire act = !(rd_strobe_n && wr_strobe_n) && !done;
  wire rd = act && !rd_strobe_n && mode != 2'h2;
  wire wr = act && !wr_strobe_n && mode != 2'h2;
  wire near = !burst_or_page_near_n;
  wire cap = rd && (cnt == 4'h2 + w || near && cnt > 4'h2 + w && cnt <= 4'h5 + w);
  wire wack = wr && cnt == (near ? 4'h2 : 4'h3) + w;
  wire rack = rd && mode == 2'h0 && cnt == 4'h2;
  wire flt = act && mode == 2'h2 && cnt == 4'hF;
  wire term = wack || flt || cap && (!near || cnt == 4'h5 + w);
  wire [31:0] word = 32'hA5000000 ^ addr ^ {30'h0, idx};
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      idx <= 2'h0;
      done <= 1'b0;
      bus_acknowledge_n <= 1'b1;
      read_word_capture_n <= 1'b1;
      bus_fault_n <= 1'b1;
      data_in <= 32'h0;
    end else begin
      cnt <= (act && !term) ? cnt + 4'h1 : 4'h0;
      done <= (act && term) || (done && !(rd_strobe_n && wr_strobe_n));
      idx <= act ? idx + {1'b0, cap} : 2'h0;
      bus_acknowledge_n <= !(rack || wack);
      read_word_capture_n <= !cap;
      bus_fault_n <= !flt;
      data_in <= cap ? word : ~word;
    end
  end
endmodule : wait_state_model

// ===== tb/ext_bus_interface_tb.sv
// self-checking bench: reads, bursts, writes and faults against the wait-state model
// assumes the model answers every strobe
`timescale 1ns/1ps
module ext_bus_interface_tb;
  logic clk_sys, arst_n, req_valid, req_write, req_burst, run_or_fixup, req_ready;
  logic rd_valid, read_fault, rd_strobe_n, wr_strobe_n, burst_or_page_near_n, data_oe_n;
  logic bus_acknowledge_n, read_word_capture_n, bus_fault_n;
  logic [31:0] req_addr, req_wdata, rd_data, addr, data_out, data_in, r, a;
  logic [3:0] req_byte_en, byte_en_n;
  logic [5:0] irq_level, irq_n, exp_irq;
  logic [1:0] mode;
  int n_errors, comparisons, seed, i;
  ext_bus_interface i_dut (.clk_sys, .arst_n, .req_valid, .req_write, .req_burst, .req_addr,
    .req_wdata, .req_byte_en, .req_ready, .rd_valid, .rd_data, .read_fault, .run_or_fixup,
    .irq_level, .rd_strobe_n, .wr_strobe_n, .burst_or_page_near_n, .byte_en_n, .addr,
    .data_out, .data_oe_n, .data_in, .bus_acknowledge_n, .read_word_capture_n,
    .bus_fault_n, .irq_n);
  wait_state_model i_ws (.clk_sys, .arst_n, .rd_strobe_n, .wr_strobe_n, .mode, .addr,
    .burst_or_page_near_n, .bus_acknowledge_n, .read_word_capture_n, .bus_fault_n, .data_in);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] exp_word(input logic [31:0] ad, input int n);
    return 32'hA5000000 ^ ad ^ 32'(n);
  endfunction : exp_word
  function automatic int exp_words(input logic w, b, input logic [1:0] m);
    return (w || m == 2'h2) ? 0 : b ? 4 : 1;
  endfunction : exp_words
  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // ==========
  // one transfer; trailing idle cycles catch late read words
  task automatic xfer(input logic w, b, input logic [1:0] m, input logic [31:0] ad);
    int n, k, idle, t;
    logic [31:0] wd;
    logic [3:0] be;
    wd = $random(seed);
    be = $random(seed);
    r = $random(seed);
    mode <= m;
    req_valid <= 1'b1;
    req_write <= w;
    req_burst <= b;
    req_addr <= ad;
    req_wdata <= wd;
    req_byte_en <= be;
    irq_n <= r[5:0];
    run_or_fixup <= r[6];
    if (r[6]) exp_irq = ~r[5:0];
    @(posedge clk_sys);
    req_valid <= 1'b0;
    n = 0;
    k = 0;
    idle = 0;
    t = 0;
    while (idle < 4 && t < 60) begin
      @(negedge clk_sys);
      t++;
      idle = (req_ready === 1'b1) ? idle + 1 : 0;
      k += (read_fault === 1'b1);
      if (rd_valid === 1'b1) begin
        check("rd_data", rd_data, exp_word(ad, n));
        n++;
      end
      if (wr_strobe_n === 1'b0) begin
        check("lanes", {data_oe_n, byte_en_n}, {1'b0, ~be});
        check("wdata", data_out, wd);
        check("addr", addr, ad);
      end
    end
    check("finished", 32'(t < 60), 32'h1);
    check("words", n, exp_words(w, b, m));
    check("fault", k, (!w && m == 2'h2) ? 1 : 0);
    check("irq", irq_level, exp_irq);
    @(posedge clk_sys);
  endtask : xfer
  initial begin
    seed = 18;
    n_errors = 0;
    comparisons = 0;
    exp_irq = 6'h3F;
    a = 32'h1000;
    {arst_n, req_valid, req_write, req_burst, run_or_fixup, mode} = 7'h00;
    {req_addr, req_wdata, req_byte_en, irq_n} = {68'h0, 6'h3F};
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    check("reset", {req_ready, irq_level}, 7'h7F);
    @(posedge clk_sys);
    xfer(1'b1, 1'b0, 2'h0, 32'h00001000);
    xfer(1'b1, 1'b0, 2'h1, 32'h000013FC);
    xfer(1'b0, 1'b1, 2'h1, 32'h00002000);
    xfer(1'b0, 1'b0, 2'h2, 32'h00002004);
    xfer(1'b1, 1'b0, 2'h2, 32'h00002008);
    for (i = 0; i < 30; i++) begin
      r = $random(seed);
      a = r[4] ? {a[31:10], r[17:10], 2'h0} : $random(seed);
      xfer(r[0], r[1], (r[3:2] == 2'h3) ? 2'h0 : r[3:2], a);
    end
    stop_test;
  end
  initial begin
    #1000000;
    n_errors++;
    stop_test;
  end
endmodule : ext_bus_interface_tb
